//--- pkg/link_cfg_pkg.sv
// constants and types for the link configuration register slice
package link_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // structure
    localparam int NUM_LINKS = 2;
    localparam int PAGE_W = 1;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 12;
    localparam int ALIGN_LANES = 3;
    localparam int ALIGN_LANE_LO = 5;

    ////////////////////////////////////////////////////////////////////////
    // register indexes, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 12'h300;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_COUNT = 12'h456;
    localparam logic [IDX_W-1:0] IDX_CONTROL_BITS_RES = 12'h457;
    localparam logic [IDX_W-1:0] IDX_SUBCLASS_WIDTH = 12'h458;
    localparam logic [IDX_W-1:0] IDX_VERSION_SAMPLES = 12'h459;
    localparam logic [IDX_W-1:0] IDX_DENSITY_CONTROL = 12'h45a;
    localparam logic [IDX_W-1:0] IDX_SPARE_ONE = 12'h45b;
    localparam logic [IDX_W-1:0] IDX_SPARE_TWO = 12'h45c;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM = 12'h45d;
    localparam logic [IDX_W-1:0] IDX_LANE_ALIGN = 12'h46c;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CS_LSB = 6;
    localparam int CS_W = 2;
    localparam int RES_LSB = 0;
    localparam int RES_W = 5;
    localparam int SUBCLASS_LSB = 5;
    localparam int SUBCLASS_W = 3;
    localparam int NP_LSB = 0;
    localparam int NP_W = 5;
    localparam int VERSION_LSB = 5;
    localparam int VERSION_W = 3;
    localparam int SAMPLES_LSB = 0;
    localparam int SAMPLES_W = 5;
    localparam int HD_BIT = 7;
    localparam int CF_LSB = 0;
    localparam int CF_W = 5;

    ////////////////////////////////////////////////////////////////////////
    // reset and fixed values
    localparam logic [7:0] RST_CONVERTER_COUNT = 8'h01;
    localparam logic [RES_W-1:0] RST_RESOLUTION = 5'h0f;
    localparam logic [SUBCLASS_W-1:0] RST_SUBCLASS = 3'h0;
    localparam logic [NP_W-1:0] RST_SAMPLE_WIDTH = 5'h0f;
    localparam logic [VERSION_W-1:0] RST_VERSION = 3'h0;
    localparam logic [SAMPLES_W-1:0] RST_SAMPLES = 5'h01;
    localparam logic [7:0] RST_SPARE = 8'h00;
    localparam logic [7:0] RST_CHECKSUM = 8'h00;
    localparam logic [CS_W-1:0] FIXED_CS = 2'h0;
    localparam logic [CF_W-1:0] FIXED_CF = 5'h00;
    localparam logic FIXED_HD = 1'b1;
    localparam logic [PAGE_W-1:0] RST_LINK_PAGE = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0] converter_count;
        logic [RES_W-1:0] resolution;
        logic [SUBCLASS_W-1:0] device_subclass_field;
        logic [NP_W-1:0] sample_width;
        logic [VERSION_W-1:0] protocol_version_field;
        logic [SAMPLES_W-1:0] samples_per_frame;
        logic [7:0] spare_param_one;
        logic [7:0] spare_param_two;
        logic [7:0] config_checksum_field;
    } link_cfg_t;

    typedef struct packed {
        logic wr;
        logic [IDX_W-1:0] index;
        logic [7:0] data;
    } reg_write_t;

endpackage : link_cfg_pkg

//--- src/level_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
module level_sync
    import link_cfg_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    ////////////////////////////////////////////////////////////////////////
    // sampling chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accept a bit once the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    stable[i] <= stage3[i];
                end
            end
        end
    end

endmodule : level_sync

//--- src/link_cfg_page.sv
// one link's copy of the writable configuration fields
module link_cfg_page
    import link_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic selected,
    input wire reg_write_t write_req,
    output link_cfg_t cfg
);

    logic hit;

    assign hit = selected && write_req.wr;

    ////////////////////////////////////////////////////////////////////////
    // converter count and resolution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.converter_count <= RST_CONVERTER_COUNT;
            cfg.resolution <= RST_RESOLUTION;
        end else if (hit) begin
            if (write_req.index == IDX_CONVERTER_COUNT) begin
                cfg.converter_count <= write_req.data;
            end
            if (write_req.index == IDX_CONTROL_BITS_RES) begin
                cfg.resolution <= write_req.data[RES_LSB +: RES_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // subclass, sample width, version and samples per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.device_subclass_field <= RST_SUBCLASS;
            cfg.sample_width <= RST_SAMPLE_WIDTH;
            cfg.protocol_version_field <= RST_VERSION;
            cfg.samples_per_frame <= RST_SAMPLES;
        end else if (hit) begin
            if (write_req.index == IDX_SUBCLASS_WIDTH) begin
                cfg.device_subclass_field <=
                    write_req.data[SUBCLASS_LSB +: SUBCLASS_W];
                cfg.sample_width <= write_req.data[NP_LSB +: NP_W];
            end
            if (write_req.index == IDX_VERSION_SAMPLES) begin
                cfg.protocol_version_field <=
                    write_req.data[VERSION_LSB +: VERSION_W];
                cfg.samples_per_frame <=
                    write_req.data[SAMPLES_LSB +: SAMPLES_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // spare fields and checksum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.spare_param_one <= RST_SPARE;
            cfg.spare_param_two <= RST_SPARE;
            cfg.config_checksum_field <= RST_CHECKSUM;
        end else if (hit) begin
            if (write_req.index == IDX_SPARE_ONE) begin
                cfg.spare_param_one <= write_req.data;
            end
            if (write_req.index == IDX_SPARE_TWO) begin
                cfg.spare_param_two <= write_req.data;
            end
            if (write_req.index == IDX_CHECKSUM) begin
                cfg.config_checksum_field <= write_req.data;
            end
        end
    end

endmodule : link_cfg_page

//--- src/link_config_param_registers.sv
// apb register slice holding paged link configuration and lane alignment
//
// Operation
// - converter count minus one, rw, resets one
// - control bit fields read only zero
// - resolution minus one, rw, resets fifteen
// - subclass field rw, resets subclass zero
// - bits per sample minus one, resets fifteen
// - protocol version field rw, resets zero
// - samples per frame minus one, resets one
// - density flag always reads one
// - two spare fields rw, reset zero
// - checksum field rw, resets zero
// - lane alignment bits read only, reset zero
// - page selector picks which link copy
module link_config_param_registers
    import link_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_LINKS*ALIGN_LANES-1:0] lane_align_raw,
    output logic [NUM_LINKS*ALIGN_LANES-1:0] lane_align_ok,
    output logic [PAGE_W-1:0] link_page,
    output link_cfg_t [NUM_LINKS-1:0] link_cfg
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_answer = 2'b01
    } bus_state_t;

    bus_state_t state;
    bus_state_t next_state;
    logic [IDX_W-1:0] index;
    logic aligned;
    logic mapped;
    logic access;
    logic commit;
    logic [7:0] read_byte;
    link_cfg_t page_cfg;
    logic [ALIGN_LANES-1:0] page_align;
    reg_write_t write_req;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign index = paddr[IDX_W+1:2];
    assign aligned = (paddr[1:0] == 2'b00) &&
                     (paddr[ADDR_W-1:IDX_W+2] == '0);
    assign access = psel && penable;
    assign commit = access && pready;

    always_comb begin
        mapped = 1'b0;
        unique case (index)
            IDX_LINK_PAGE,
            IDX_CONVERTER_COUNT,
            IDX_CONTROL_BITS_RES,
            IDX_SUBCLASS_WIDTH,
            IDX_VERSION_SAMPLES,
            IDX_DENSITY_CONTROL,
            IDX_SPARE_ONE,
            IDX_SPARE_TWO,
            IDX_CHECKSUM,
            IDX_LANE_ALIGN: begin
                mapped = aligned;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // page selection of the stored copies
    always_comb begin
        page_cfg = link_cfg[link_page];
        page_align =
            lane_align_ok[link_page*ALIGN_LANES +: ALIGN_LANES];
    end

    ////////////////////////////////////////////////////////////////////////
    // read data assembly
    always_comb begin
        read_byte = 8'h00;
        unique case (index)
            IDX_LINK_PAGE: begin
                read_byte[PAGE_W-1:0] = link_page;
            end
            IDX_CONVERTER_COUNT: begin
                read_byte = page_cfg.converter_count;
            end
            IDX_CONTROL_BITS_RES: begin
                read_byte[CS_LSB +: CS_W] = FIXED_CS;
                read_byte[RES_LSB +: RES_W] = page_cfg.resolution;
            end
            IDX_SUBCLASS_WIDTH: begin
                read_byte[SUBCLASS_LSB +: SUBCLASS_W] =
                    page_cfg.device_subclass_field;
                read_byte[NP_LSB +: NP_W] = page_cfg.sample_width;
            end
            IDX_VERSION_SAMPLES: begin
                read_byte[VERSION_LSB +: VERSION_W] =
                    page_cfg.protocol_version_field;
                read_byte[SAMPLES_LSB +: SAMPLES_W] =
                    page_cfg.samples_per_frame;
            end
            IDX_DENSITY_CONTROL: begin
                read_byte[HD_BIT] = FIXED_HD;
                read_byte[CF_LSB +: CF_W] = FIXED_CF;
            end
            IDX_SPARE_ONE: begin
                read_byte = page_cfg.spare_param_one;
            end
            IDX_SPARE_TWO: begin
                read_byte = page_cfg.spare_param_two;
            end
            IDX_CHECKSUM: begin
                read_byte = page_cfg.config_checksum_field;
            end
            IDX_LANE_ALIGN: begin
                read_byte[ALIGN_LANE_LO +: ALIGN_LANES] = page_align;
            end
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshake state
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (access) begin
                    next_state = st_answer;
                end
            end
            st_answer: begin
                next_state = st_idle;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= (state == st_idle) && access;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if ((state == st_idle) && access) begin
            pslverr <= !mapped;
            if (mapped && !pwrite) begin
                prdata <= {24'h00_0000, read_byte};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write request, taken at the edge that completes the access
    always_comb begin
        write_req.wr = commit && pwrite && mapped && pstrb[0];
        write_req.index = index;
        write_req.data = pwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // link page selector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_page <= RST_LINK_PAGE;
        end else if (write_req.wr && (index == IDX_LINK_PAGE)) begin
            link_page <= pwdata[PAGE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per link storage
    for (genvar g = 0; g < NUM_LINKS; g++) begin : gen_page
        link_cfg_page u_page (
            .pclk(pclk),
            .presetn(presetn),
            .selected(link_page == PAGE_W'(g)),
            .write_req(write_req),
            .cfg(link_cfg[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // lane alignment status from the deframer pins
    level_sync #(
        .WIDTH(NUM_LINKS*ALIGN_LANES)
    ) u_align_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw(lane_align_raw),
        .stable(lane_align_ok)
    );

endmodule : link_config_param_registers

//--- verif/link_config_param_registers_bench.sv
// self-checking bench for the link configuration register slice
module link_config_param_registers_bench
    import link_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_LINKS*ALIGN_LANES-1:0] lane_align_raw = 6'h00;
    logic [NUM_LINKS*ALIGN_LANES-1:0] lane_align_ok;
    logic [PAGE_W-1:0] link_page;
    link_cfg_t [NUM_LINKS-1:0] link_cfg;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic err;
    logic [1:0] lo_bits = 2'b00;

    link_config_param_registers i_link_config_param_registers (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .lane_align_raw, .lane_align_ok, .link_page,
        .link_cfg);

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [IDX_W-1:0] ix,
            input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ix, lo_bits};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [IDX_W-1:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        chk({31'h0, err}, 32'h0);
        chk(rd, {24'h000000, e});
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rdchk(IDX_LINK_PAGE, 8'h00);
        rdchk(IDX_CONVERTER_COUNT, 8'h01);
        rdchk(IDX_CONTROL_BITS_RES, 8'h0f);
        rdchk(IDX_SUBCLASS_WIDTH, 8'h0f);
        rdchk(IDX_VERSION_SAMPLES, 8'h01);
        rdchk(IDX_DENSITY_CONTROL, 8'h80);
        rdchk(IDX_SPARE_ONE, 8'h00);
        rdchk(IDX_SPARE_TWO, 8'h00);
        rdchk(IDX_CHECKSUM, 8'h00);
        rdchk(IDX_LANE_ALIGN, 8'h00);
        $display("reset values test done");
    endtask : t_reset

    task automatic t_paged();
        logic [IDX_W-1:0] ix [8];
        logic [7:0] wv [2][8];
        logic [7:0] ev [2][8];
        ix = '{IDX_CONVERTER_COUNT, IDX_CONTROL_BITS_RES, IDX_SUBCLASS_WIDTH,
            IDX_VERSION_SAMPLES, IDX_DENSITY_CONTROL, IDX_SPARE_ONE,
            IDX_SPARE_TWO, IDX_CHECKSUM};
        wv = '{'{8'ha5, 8'hff, 8'h3a, 8'h22, 8'h00, 8'h5a, 8'hc3, 8'h7e},
            '{8'h3c, 8'he4, 8'h1f, 8'h03, 8'hff, 8'h96, 8'h0f, 8'he1}};
        ev = '{'{8'ha5, 8'h1f, 8'h3a, 8'h22, 8'h80, 8'h5a, 8'hc3, 8'h7e},
            '{8'h3c, 8'h04, 8'h1f, 8'h03, 8'h80, 8'h96, 8'h0f, 8'he1}};
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, IDX_LINK_PAGE, p[7:0]);
            for (int i = 0; i < 8; i++) apb(1'b1, ix[i], wv[p][i]);
        end
        pstrb <= 4'h0;
        apb(1'b1, IDX_SPARE_ONE, 8'h00);
        pstrb <= 4'hf;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, IDX_LINK_PAGE, p[7:0]);
            for (int i = 0; i < 8; i++) begin
                rdchk(ix[i], ev[p][i]);
            end
        end
        chk({24'h0, link_cfg[0].converter_count}, 32'ha5);
        chk({24'h0, link_cfg[1].spare_param_one}, 32'h96);
        chk({24'h0, link_cfg[1].config_checksum_field}, 32'he1);
        $display("paged write test done");
    endtask : t_paged

    task automatic t_align();
        lane_align_raw <= 6'h2b;
        repeat (8) @(posedge pclk);
        chk({26'h0, lane_align_ok}, 32'h2b);
        apb(1'b1, IDX_LINK_PAGE, 8'h00);
        apb(1'b1, IDX_LANE_ALIGN, 8'h1f);
        rdchk(IDX_LANE_ALIGN, 8'h60);
        apb(1'b1, IDX_LINK_PAGE, 8'h01);
        rdchk(IDX_LANE_ALIGN, 8'ha0);
        chk({31'h0, link_page}, 32'h1);
        $display("lane alignment test done");
    endtask : t_align

    task automatic t_unmapped();
        apb(1'b0, 12'h460, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        lo_bits = 2'b01;
        apb(1'b1, IDX_SPARE_ONE, 8'h55);
        lo_bits = 2'b00;
        chk({31'h0, err}, 32'h1);
        rdchk(IDX_SPARE_ONE, 8'h96);
        $display("unmapped access test done");
    endtask : t_unmapped

    ////////////////////////////////////////////////////////////////////////
    // sequence and timeout
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_paged();
        t_align();
        t_unmapped();
        tally_and_finish();
    end
endmodule : link_config_param_registers_bench

//--- verif/link_config_param_registers_properties.sv
// concurrent checks for the link configuration register slice
module link_config_param_registers_properties
    import link_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_LINKS*ALIGN_LANES-1:0] lane_align_raw,
    input wire logic [NUM_LINKS*ALIGN_LANES-1:0] lane_align_ok,
    input wire logic [PAGE_W-1:0] link_page,
    input wire link_cfg_t [NUM_LINKS-1:0] link_cfg
);
    wire logic [IDX_W-1:0] idx = paddr[13:2];
    wire logic rd = pready && !pwrite && !pslverr;
    wire logic wr = pready && pwrite && pstrb[0] && !pslverr;
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic [PAGE_W-1:0] wpage = pwdata[PAGE_W-1:0];
    wire logic [2:0] sel_align = link_page[0] ? lane_align_ok[5:3]
        : lane_align_ok[2:0];
    wire logic mapped = paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0
        && idx inside {IDX_LINK_PAGE, IDX_CONVERTER_COUNT,
        IDX_CONTROL_BITS_RES, IDX_SUBCLASS_WIDTH, IDX_VERSION_SAMPLES,
        IDX_DENSITY_CONTROL, IDX_SPARE_ONE, IDX_SPARE_TWO, IDX_CHECKSUM,
        IDX_LANE_ALIGN};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // bus timing
    a_ready_one_wait: assert property (
        (psel && !penable) |=> !pready ##1 pready)
        else $error("pready not after one wait cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside answer");
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_unmapped_err: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");

    ////////////////////////////////////////////////////////////////////////
    // field behaviour
    a_density_fixed: assert property (
        rd && idx == IDX_DENSITY_CONTROL |-> prdata[7:0] == 8'h80)
        else $error("density word wrong");
    a_cs_fixed: assert property (
        rd && idx == IDX_CONTROL_BITS_RES |-> prdata[7:5] == 3'h0)
        else $error("control bits not zero");
    a_align_read: assert property (
        rd && idx == IDX_LANE_ALIGN
        |-> prdata[4:0] == 5'h0 && prdata[7:5] == $past(sel_align))
        else $error("lane alignment read wrong");
    a_page_write: assert property (
        wr && idx == IDX_LINK_PAGE |=> link_page == $past(wpage))
        else $error("page selector not written");
    a_count_write: assert property (
        wr && idx == IDX_CONVERTER_COUNT && link_page == 1'h0
        |=> link_cfg[0].converter_count == $past(wbyte))
        else $error("converter count not written");
    a_cfg_hold: assert property (
        !(pready && pwrite && pstrb[0]) |=> $stable(link_cfg))
        else $error("config changed without write");
endmodule : link_config_param_registers_properties

bind link_config_param_registers link_config_param_registers_properties
    i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .lane_align_raw, .lane_align_ok,
    .link_page, .link_cfg);
